// ===== hw/esar_pkg.sv
package esar_pkg;

  // Register offsets on the parallel control port
  localparam logic [7:0] OFS_RX_ALARM_STATUS  = 8'h06;
  localparam logic [7:0] OFS_EVENT_STATUS_TWO = 8'h07;
  localparam logic [7:0] OFS_RX_INFORMATION   = 8'h08;
  localparam logic [7:0] OFS_ALARM_MASK_ONE   = 8'h16;
  localparam logic [7:0] OFS_EVENT_MASK_TWO   = 8'h17;
  localparam logic [7:0] OFS_SYNC_LIVE_STATUS = 8'h1e;

  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK   = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // receive_alarm_status field positions
  localparam int BIT_SIG_ALL_ONES   = 7;
  localparam int BIT_DISTANT_MF     = 6;
  localparam int BIT_SIG_ALL_ZEROS  = 5;
  localparam int BIT_RX_SLIP        = 4;
  localparam int BIT_UNFRAMED_ONES  = 3;
  localparam int BIT_REMOTE_ALARM   = 2;
  localparam int BIT_CARRIER_LOSS   = 1;
  localparam int BIT_LOSS_OF_SYNC   = 0;
  // Alarm-type bits of receive_alarm_status
  localparam logic [7:0] ALARM_BITS_ONE = 8'h0f;
  localparam logic [7:0] ALARM_BITS_NONE = 8'h00;

  // receive_information field positions
  localparam int BIT_TX_STORE_FULL  = 7;
  localparam int BIT_TX_STORE_EMPTY = 6;
  localparam int BIT_JITTER_TRIP    = 5;
  localparam int BIT_RX_STORE_FULL  = 4;
  localparam int BIT_RX_STORE_EMPTY = 3;
  localparam int BIT_CRC_RESYNC     = 2;
  localparam int BIT_FAS_RESYNC     = 1;
  localparam int BIT_CAS_RESYNC     = 0;

  // Detector figures
  localparam int SIG_ONES_ZEROS_MIN = 3;
  localparam int DMA_RUN            = 2;
  localparam int UAO_WINDOW_BITS    = 512;
  localparam int UAO_ZEROS_MIN      = 3;
  localparam int RRA_RUN            = 3;
  localparam int RCL_ZEROS_NORMAL   = 255;
  localparam int RCL_ZEROS_ALT      = 2048;
  localparam int RCL_CLEAR_WINDOW   = 255;
  localparam int RCL_CLEAR_ONES     = 32;
  localparam int CRC_BLOCK_WORDS    = 1000;
  localparam int CRC_BLOCK_ERRORS   = 915;
  localparam int FAS_ERR_RUN        = 3;
  localparam int JITTER_MARGIN      = 4;
  localparam int SYNC_COUNT_WIDTH   = 6;

  // Receive stream qualifiers from the framer, one bit time per bit_en
  typedef struct packed {
    logic bit_en;
    logic bit_value;
    logic in_ts16;
    logic ts16_bit6;
    logic frame_zero;
    logic nonalign_bit3;
    logic mf_end;
  } esar_rx_stream_type;

  // Framer and store events, single-cycle pulses except in_sync, crc_synced and the three search bits, which are levels
  typedef struct packed {
    logic signaling_change;
    logic rx_slip;
    logic in_sync;
    logic tx_full;
    logic tx_empty;
    logic rx_full;
    logic rx_empty;
    logic crc_word_valid;
    logic crc_word_error;
    logic fas_word_valid;
    logic fas_word_error;
    logic cas_resync;
    logic mf_search_timeout;
    logic crc_synced;
    logic frame_search;
    logic signaling_search;
    logic crc_search;
  } esar_framer_type;

  // Host access, one-cycle strobes
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } esar_host_type;

endpackage

// ===== hw/esar_latch_reg.sv
module esar_latch_reg #(
  parameter int          WIDTH = 8,
  parameter logic [7:0]  ALARM = 8'h00
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] set_event,
  input  wire logic [WIDTH-1:0] alarm_level,
  input  wire logic             write_en,
  input  wire logic             read_en,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [WIDTH-1:0] irq_mask,
  output logic      [WIDTH-1:0] read_copy,
  output logic                  irq
);
  import esar_pkg::*;

  logic [WIDTH-1:0] latched;
  logic [WIDTH-1:0] selected;
  logic [WIDTH-1:0] pending;
  logic [WIDTH-1:0] alarm_prev;
  logic [WIDTH-1:0] alarm_kind;
  logic [WIDTH-1:0] read_clear;
  logic [WIDTH-1:0] pend_clear;
  logic [WIDTH-1:0] alarm_change;
  logic [WIDTH-1:0] next_latched;
  logic [WIDTH-1:0] next_pending;
  logic [WIDTH-1:0] next_copy;

  assign alarm_kind   = ALARM[WIDTH-1:0];
  assign read_clear   = read_en ? (selected & read_copy) : '0;
  assign pend_clear   = read_en ? selected : '0;
  assign alarm_change = (alarm_level ^ alarm_prev) & alarm_kind;
  // Set wins over a read clear; alarms stay set while present
  assign next_latched = (latched & ~read_clear) | set_event
                      | (alarm_level & alarm_kind); // RULE_01 RULE_02
  // Copy refreshed only where the mask byte holds a one
  assign next_copy    = write_en ? ((read_copy & ~wdata) | (latched & wdata))
                                 : read_copy; // RULE_03
  assign next_pending = (pending & ~pend_clear) | alarm_change
                      | (set_event & ~alarm_kind); // RULE_07 RULE_08 RULE_09
  assign irq          = |(pending & irq_mask); // RULE_06

  always_ff @(posedge clock) begin
    if (rst) begin
      latched    <= '0;
      selected   <= '0;
      pending    <= '0;
      alarm_prev <= '0;
      read_copy  <= '0;
    end else begin
      latched    <= next_latched;
      pending    <= next_pending;
      alarm_prev <= alarm_level;
      read_copy  <= next_copy;
      if (write_en) begin
        selected <= wdata;
      end
    end
  end

endmodule // esar_latch_reg

// ===== hw/esar_e1_status_alarm.sv
// Operation
// RULE_01 - Both status registers and information register bits latch at one.
// RULE_02 - Reading a bit clears it; the four alarms re-set while present.
// RULE_03 - A write refreshes the readable copy only where written one.
// RULE_04 - Host writes mask, reads, then writes read value ANDed with mask.
// RULE_05 - Synchronizer status is read-only, live, needs no mask write.
// RULE_06 - Every status bit has its own interrupt mask bit.
// RULE_07 - Alarm bits request an interrupt on every change of state.
// RULE_08 - Reading the alarm bit drops its request even while present.
// RULE_09 - Event bits request on the event, drop when read.
// RULE_10 - Elastic store full and empty flags set on delete or repeat.
// RULE_11 - Jitter trip flag sets within four bits of the limit.
// RULE_12 - CRC resync flag sets on 915 errored words out of 1000.
// RULE_13 - Frame resync flag sets on three frame words errored in a row.
// RULE_14 - Three search-active bits show frame, signaling and CRC hunts.
// RULE_15 - Sync counter bits 5..2 and 0 readable; bit 1 hidden.
// RULE_16 - Sync counter counts timeouts, clears on sync or mode off, wraps.
// RULE_17 - Signaling ones: fewer than three zeros in TS16 over 16 frames.
// RULE_18 - A signaling change sets both signaling flags.
// RULE_19 - Signaling zeros: TS16 all zero over one multiframe.
// RULE_20 - Distant multiframe alarm after two multiframes of bit 6 set.
// RULE_21 - Unframed all ones: fewer than three zeros in 512 bits.
// RULE_22 - Remote alarm after three non-align bit 3 ones, clears on zeros.
// RULE_23 - Carrier loss on 255 or 2048 zeros; cleared by 32 ones in 255.
// RULE_24 - Slip bit latches on store slip; sync loss while unsynchronized.
// RULE_25 - Interrupt pin low while any unmasked request stays unserviced.
module esar_e1_status_alarm (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire esar_pkg::esar_host_type      host,
  output logic      [7:0]                   host_rdata,
  input  wire esar_pkg::esar_rx_stream_type rx,
  input  wire esar_pkg::esar_framer_type    framer,
  input  wire logic                         rx_positive_in,
  input  wire logic                         rx_negative_in,
  input  wire logic [7:0]                   event_two,
  input  wire logic [7:0]                   jitter_fill,
  input  wire logic [7:0]                   jitter_limit,
  input  wire logic                         crc_mode_enable,
  input  wire logic                         carrier_loss_alt_criterion,
  input  wire logic                         link_controller_irq,
  output logic                              irq_n
);
  import esar_pkg::*;

  // Line mark synchroniser
  logic        pos_meta;
  logic        pos_sync;
  logic        neg_meta;
  logic        neg_sync;
  logic        line_mark;

  // Host decode
  logic        sel_alarm;
  logic        sel_event_two;
  logic        sel_info;
  logic        sel_mask_one;
  logic        sel_mask_two;
  logic        sel_sync;
  logic [7:0]  read_mux;

  // Mask registers
  logic [7:0]  alarm_mask_one;
  logic [7:0]  event_mask_two;

  // Signaling detectors
  logic [1:0]  ts16_zeros;
  logic        ts16_any_one;
  logic        mf_bit6;
  logic [1:0]  dma_ones;
  logic [1:0]  dma_zeros;
  logic        distant_multiframe_alarm;
  logic        dma_set;

  // Unframed all ones
  logic [8:0]  uao_bits;
  logic [1:0]  uao_zeros;
  logic        unframed_all_ones;

  // Remote alarm
  logic [1:0]  rra_ones;
  logic [1:0]  rra_zeros;
  logic        remote_alarm_rx;

  // Carrier loss
  logic [11:0] rcl_zero_run;
  logic [7:0]  rcl_window;
  logic [5:0]  rcl_ones;
  logic        carrier_loss;
  logic [11:0] rcl_limit;

  // Resync criteria
  logic [9:0]  crc_words;
  logic [9:0]  crc_errors;
  logic        crc_resync_met;
  logic [1:0]  fas_run;
  logic        frame_align_resync_met;
  logic        jitter_limit_trip;

  // Synchronizer counter
  logic [SYNC_COUNT_WIDTH-1:0] sync_count;
  logic [7:0]  synchronizer_live_status;

  // Status register plumbing
  logic [7:0]  alarm_events;
  logic [7:0]  alarm_levels;
  logic [7:0]  info_events;
  logic [7:0]  copy_alarm;
  logic [7:0]  copy_event_two;
  logic [7:0]  copy_info;
  logic        irq_alarm;
  logic        irq_event_two;
  logic        ts16_bit;
  logic        mf_eval;

  function automatic logic [1:0] sat_inc2(input logic [1:0] value);
    sat_inc2 = (value == 2'h3) ? value : value + 2'h1;
  endfunction

  // Host address decode
  assign sel_alarm     = host.addr == OFS_RX_ALARM_STATUS;
  assign sel_event_two = host.addr == OFS_EVENT_STATUS_TWO;
  assign sel_info      = host.addr == OFS_RX_INFORMATION;
  assign sel_mask_one  = host.addr == OFS_ALARM_MASK_ONE;
  assign sel_mask_two  = host.addr == OFS_EVENT_MASK_TWO;
  assign sel_sync      = host.addr == OFS_SYNC_LIVE_STATUS;

  assign read_mux = sel_alarm     ? copy_alarm :
                    sel_event_two ? copy_event_two :
                    sel_info      ? copy_info :
                    sel_mask_one  ? alarm_mask_one :
                    sel_mask_two  ? event_mask_two :
                    sel_sync      ? synchronizer_live_status : // RULE_05
                                    RD_UNMAPPED;

  // Receive stream qualifiers
  assign line_mark = pos_sync | neg_sync;
  assign ts16_bit  = rx.bit_en & rx.in_ts16;
  assign mf_eval   = rx.bit_en & rx.mf_end;

  always_ff @(posedge clock) begin
    if (rst) begin
      pos_meta <= 1'b0;
      pos_sync <= 1'b0;
      neg_meta <= 1'b0;
      neg_sync <= 1'b0;
    end else begin
      pos_meta <= rx_positive_in;
      pos_sync <= pos_meta;
      neg_meta <= rx_negative_in;
      neg_sync <= neg_meta;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      alarm_mask_one <= RST_MASK;
      event_mask_two <= RST_MASK;
      host_rdata     <= RD_UNMAPPED;
    end else begin
      if (host.wr && sel_mask_one) begin
        alarm_mask_one <= host.wdata; // RULE_06
      end
      if (host.wr && sel_mask_two) begin
        event_mask_two <= host.wdata; // RULE_06
      end
      if (host.rd) begin
        host_rdata <= read_mux;
      end
    end
  end

  // Signaling all ones / all zeros over one multiframe
  always_ff @(posedge clock) begin
    if (rst) begin
      ts16_zeros          <= 2'h0;
      ts16_any_one        <= 1'b0;
    end else if (mf_eval) begin
      ts16_zeros          <= 2'h0;
      ts16_any_one        <= 1'b0;
    end else if (ts16_bit) begin
      if (!rx.bit_value) begin
        ts16_zeros <= sat_inc2(ts16_zeros);
      end else begin
        ts16_any_one <= 1'b1;
      end
    end
  end

  // Distant multiframe alarm
  assign dma_set = mf_eval && mf_bit6 && 32'(dma_ones) + 1 >= DMA_RUN;

  always_ff @(posedge clock) begin
    if (rst) begin
      mf_bit6                  <= 1'b0;
      dma_ones                 <= 2'h0;
      dma_zeros                <= 2'h0;
      distant_multiframe_alarm <= 1'b0;
    end else begin
      if (ts16_bit && rx.frame_zero && rx.ts16_bit6) begin
        mf_bit6 <= rx.bit_value;
      end
      if (mf_eval) begin
        dma_ones  <= mf_bit6 ? sat_inc2(dma_ones) : 2'h0;
        dma_zeros <= mf_bit6 ? 2'h0 : sat_inc2(dma_zeros);
        if (dma_set) begin
          distant_multiframe_alarm <= 1'b1; // RULE_20
        end else if (!mf_bit6 && 32'(dma_zeros) + 1 >= DMA_RUN) begin
          distant_multiframe_alarm <= 1'b0; // RULE_20
        end
      end
    end
  end

  // Unframed all ones over a 512-bit window
  always_ff @(posedge clock) begin
    if (rst) begin
      uao_bits          <= 9'h000;
      uao_zeros         <= 2'h0;
      unframed_all_ones <= 1'b0;
    end else if (rx.bit_en) begin
      uao_bits <= uao_bits + 9'h001;
      if (32'(uao_bits) == UAO_WINDOW_BITS - 1) begin
        unframed_all_ones <= 32'(uao_zeros) + (rx.bit_value ? 0 : 1)
                             < UAO_ZEROS_MIN; // RULE_21
        uao_zeros         <= 2'h0;
      end else if (!rx.bit_value) begin
        uao_zeros <= sat_inc2(uao_zeros);
      end
    end
  end

  // Remote alarm from non-align frame bit 3
  always_ff @(posedge clock) begin
    if (rst) begin
      rra_ones        <= 2'h0;
      rra_zeros       <= 2'h0;
      remote_alarm_rx <= 1'b0;
    end else if (rx.bit_en && rx.nonalign_bit3) begin
      rra_ones  <= rx.bit_value ? sat_inc2(rra_ones) : 2'h0;
      rra_zeros <= rx.bit_value ? 2'h0 : sat_inc2(rra_zeros);
      if (rx.bit_value && 32'(rra_ones) + 1 >= RRA_RUN) begin
        remote_alarm_rx <= 1'b1; // RULE_22
      end else if (!rx.bit_value && 32'(rra_zeros) + 1 >= RRA_RUN) begin
        remote_alarm_rx <= 1'b0; // RULE_22
      end
    end
  end

  // Carrier loss on line marks
  assign rcl_limit = carrier_loss_alt_criterion ? 12'(RCL_ZEROS_ALT - 1)
                                                : 12'(RCL_ZEROS_NORMAL - 1);

  always_ff @(posedge clock) begin
    if (rst) begin
      rcl_zero_run <= 12'h000;
      rcl_window   <= 8'h00;
      rcl_ones     <= 6'h00;
      carrier_loss <= 1'b0;
    end else if (rx.bit_en) begin
      if (line_mark) begin
        rcl_zero_run <= 12'h000;
      end else if (rcl_zero_run != rcl_limit) begin
        rcl_zero_run <= rcl_zero_run + 12'h001;
      end
      if (!line_mark && rcl_zero_run == rcl_limit) begin
        carrier_loss <= 1'b1; // RULE_23
      end else if (line_mark && 32'(rcl_ones) + 1 >= RCL_CLEAR_ONES) begin
        carrier_loss <= 1'b0; // RULE_23
      end
      if (32'(rcl_window) == RCL_CLEAR_WINDOW - 1) begin
        rcl_window <= 8'h00;
        rcl_ones   <= 6'h00;
      end else begin
        rcl_window <= rcl_window + 8'h01;
        if (line_mark && rcl_ones != 6'h3f) begin
          rcl_ones <= rcl_ones + 6'h01;
        end
      end
    end
  end

  // CRC and frame resync criteria
  always_ff @(posedge clock) begin
    if (rst) begin
      crc_words              <= 10'h000;
      crc_errors             <= 10'h000;
      crc_resync_met         <= 1'b0;
      fas_run                <= 2'h0;
      frame_align_resync_met <= 1'b0;
    end else begin
      crc_resync_met         <= 1'b0;
      frame_align_resync_met <= 1'b0;
      if (framer.crc_word_valid) begin
        if (32'(crc_words) == CRC_BLOCK_WORDS - 1) begin
          crc_words  <= 10'h000;
          crc_errors <= 10'h000;
        end else begin
          crc_words  <= crc_words + 10'h001;
          crc_errors <= crc_errors + 10'(framer.crc_word_error);
        end
        if (framer.crc_word_error &&
            32'(crc_errors) == CRC_BLOCK_ERRORS - 1) begin
          crc_resync_met <= 1'b1; // RULE_12
        end
      end
      if (framer.fas_word_valid) begin
        fas_run <= framer.fas_word_error ? sat_inc2(fas_run) : 2'h0;
        if (framer.fas_word_error && 32'(fas_run) + 1 == FAS_ERR_RUN) begin
          frame_align_resync_met <= 1'b1; // RULE_13
        end
      end
    end
  end

  assign jitter_limit_trip = 9'(jitter_fill) + 9'(JITTER_MARGIN)
                             >= 9'(jitter_limit); // RULE_11

  // CRC4 sync counter, wraps
  always_ff @(posedge clock) begin
    if (rst) begin
      sync_count <= '0;
    end else if (framer.crc_synced || !crc_mode_enable) begin
      sync_count <= '0; // RULE_16
    end else if (framer.mf_search_timeout) begin
      sync_count <= sync_count + SYNC_COUNT_WIDTH'(1); // RULE_16
    end
  end

  assign synchronizer_live_status = {sync_count[5:2], sync_count[0], // RULE_15
                                     framer.frame_search,
                                     framer.signaling_search,
                                     framer.crc_search}; // RULE_14

  // Status sources
  always_comb begin
    alarm_events = 8'h00;
    alarm_levels = 8'h00;
    alarm_events[BIT_SIG_ALL_ONES]  = (mf_eval && 32'(ts16_zeros)
                                       < SIG_ONES_ZEROS_MIN)
                                    || framer.signaling_change; // RULE_17 RULE_18
    alarm_events[BIT_SIG_ALL_ZEROS] = (mf_eval && !ts16_any_one)
                                    || framer.signaling_change; // RULE_19 RULE_18
    alarm_events[BIT_DISTANT_MF]    = dma_set;
    alarm_events[BIT_RX_SLIP]       = framer.rx_slip; // RULE_24
    alarm_levels[BIT_UNFRAMED_ONES] = unframed_all_ones;
    alarm_levels[BIT_REMOTE_ALARM]  = remote_alarm_rx;
    alarm_levels[BIT_CARRIER_LOSS]  = carrier_loss;
    alarm_levels[BIT_LOSS_OF_SYNC]  = !framer.in_sync; // RULE_24
  end

  always_comb begin
    info_events = 8'h00;
    info_events[BIT_TX_STORE_FULL]  = framer.tx_full; // RULE_10
    info_events[BIT_TX_STORE_EMPTY] = framer.tx_empty; // RULE_10
    info_events[BIT_JITTER_TRIP]    = jitter_limit_trip;
    info_events[BIT_RX_STORE_FULL]  = framer.rx_full; // RULE_10
    info_events[BIT_RX_STORE_EMPTY] = framer.rx_empty; // RULE_10
    info_events[BIT_CRC_RESYNC]     = crc_resync_met;
    info_events[BIT_FAS_RESYNC]     = frame_align_resync_met;
    info_events[BIT_CAS_RESYNC]     = framer.cas_resync;
  end

  esar_latch_reg #(.WIDTH(8), .ALARM(ALARM_BITS_ONE)) u_alarm_status (
    .clock       (clock),
    .rst         (rst),
    .set_event   (alarm_events),
    .alarm_level (alarm_levels),
    .write_en    (host.wr && sel_alarm),
    .read_en     (host.rd && sel_alarm),
    .wdata       (host.wdata),
    .irq_mask    (alarm_mask_one),
    .read_copy   (copy_alarm),
    .irq         (irq_alarm)
  );

  esar_latch_reg #(.WIDTH(8), .ALARM(ALARM_BITS_NONE)) u_event_two (
    .clock       (clock),
    .rst         (rst),
    .set_event   (event_two),
    .alarm_level (8'h00),
    .write_en    (host.wr && sel_event_two),
    .read_en     (host.rd && sel_event_two),
    .wdata       (host.wdata),
    .irq_mask    (event_mask_two),
    .read_copy   (copy_event_two),
    .irq         (irq_event_two)
  );

  // Information register does not interrupt
  esar_latch_reg #(.WIDTH(8), .ALARM(ALARM_BITS_NONE)) u_information (
    .clock       (clock),
    .rst         (rst),
    .set_event   (info_events),
    .alarm_level (8'h00),
    .write_en    (host.wr && sel_info),
    .read_en     (host.rd && sel_info),
    .wdata       (host.wdata),
    .irq_mask    (8'h00),
    .read_copy   (copy_info),
    .irq         ()
  );

  // Interrupt pin, active low
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(irq_alarm || irq_event_two
                 || link_controller_irq); // RULE_25
    end
  end

endmodule // esar_e1_status_alarm

// ===== verif/esar_rx_src.sv
module esar_rx_src (
  input  wire logic                  clock,
  input  wire logic                  ones,
  output esar_pkg::esar_rx_stream_type rx,
  output logic                       pos,
  output logic                       neg
);
  timeunit 1ns;
  timeprecision 1ps;
  import esar_pkg::*;
  logic polar = 1'b0;
  initial begin
    rx = '0;
    pos = 1'b0;
    neg = 1'b0;
  end
  // One bit time per cycle, alternate mark inversion
  always @(negedge clock) begin
    polar <= polar ^ ones;
    rx <= '{bit_en: 1'b1, bit_value: ones, default: 1'b0};
    pos <= ones & ~polar;
    neg <= ones & polar;
  end
endmodule // esar_rx_src

// ===== verif/esar_chk.sv
module esar_chk (
  input wire logic                  clock,
  input wire logic                  rst,
  input wire esar_pkg::esar_host_type host,
  input wire logic [7:0]            host_rdata,
  input wire esar_pkg::esar_framer_type framer,
  input wire logic                  crc_mode_enable,
  input wire logic                  link_controller_irq,
  input wire logic                  irq_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import esar_pkg::*;
  logic [15:0] mask;
  logic [2:0]  search_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      mask <= 16'h0000;
    end else if (host.wr && host.addr == OFS_ALARM_MASK_ONE) begin
      mask[7:0] <= host.wdata;
    end else if (host.wr && host.addr == OFS_EVENT_MASK_TWO) begin
      mask[15:8] <= host.wdata;
    end
  end
  always_ff @(posedge clock) begin
    search_q <= {framer.frame_search, framer.signaling_search,
                 framer.crc_search};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  AST_RST_VAL: assert property ($fell(rst) |-> irq_n &&
    host_rdata == RST_STATUS) else $error("reset values wrong");
  AST_SEARCH_LIVE: assert property (host.rd &&
    host.addr == OFS_SYNC_LIVE_STATUS |=> host_rdata[2:0] == search_q)
    else $error("search bits not live");
  AST_CNT_OFF: assert property (host.rd &&
    host.addr == OFS_SYNC_LIVE_STATUS && !crc_mode_enable &&
    !$past(crc_mode_enable) |=> host_rdata[7:3] == 5'h00)
    else $error("sync counter not held at zero");
  AST_RD_HOLD: assert property (!host.rd |=>
    $stable(host_rdata)) else $error("read data changed without read");
  AST_LINK_IRQ: assert property (link_controller_irq |->
    ##[1:2] !irq_n) else $error("link request not on irq_n");
  AST_SLIP_IRQ: assert property (framer.rx_slip &&
    mask[BIT_RX_SLIP] |-> ##[1:3] !irq_n) else $error("slip irq missing");
  AST_IDLE_HIGH: assert property ((mask == 16'h0000 &&
    !link_controller_irq)[*3] |-> irq_n) else $error("masked irq seen");
  AST_FALL_CAUSE: assert property ($fell(irq_n) |->
    $past(mask) != 16'h0000 || $past(link_controller_irq) ||
    $past(link_controller_irq, 2)) else $error("irq without source");
  cover property (link_controller_irq);
  cover property (framer.rx_slip && mask[BIT_RX_SLIP]);
  cover property ($rose(irq_n));
endmodule // esar_chk
bind esar_e1_status_alarm esar_chk u_chk (.*);

// ===== verif/e1_status_alarm_registers_tb.sv
module e1_status_alarm_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import esar_pkg::*;
  logic               clock = 1'b0;
  logic               rst = 1'b1;
  esar_host_type      host = '0;
  esar_framer_type    fr = 17'h04004;
  esar_rx_stream_type rx;
  logic [7:0]         rdata, v, ev2 = 8'h00, jfill = 8'h5f;
  logic [5:0]         c;
  logic               pos, neg, irq_n, ones = 1'b1, crc_en = 1'b0;
  logic               link_irq = 1'b0, alt = 1'b0;
  int                 fails = 0, n_compared = 0, n;
  always #4 clock = ~clock;
  esar_rx_src u_src (.clock, .ones, .rx, .pos, .neg);
  esar_e1_status_alarm u_dut (.clock, .rst, .host, .host_rdata(rdata),
    .rx, .framer(fr), .rx_positive_in(pos), .rx_negative_in(neg),
    .event_two(ev2), .jitter_fill(jfill), .jitter_limit(8'h64),
    .crc_mode_enable(crc_en), .carrier_loss_alt_criterion(alt),
    .link_controller_irq(link_irq), .irq_n);
  task print_verdict();
    $display("Compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock) host <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clock) host <= '0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock) host <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clock) host <= '0;
    d = rdata;
  endtask
  task pulse(input logic [16:0] p);
    @(negedge clock) fr <= fr | p;
    @(negedge clock) fr <= fr & ~p;
  endtask
  task wait_irq(input logic lvl, input int lim, output int cyc);
    cyc = 0;
    while (irq_n !== lvl && cyc < lim) begin
      @(negedge clock);
      cyc++;
    end
    chk({7'h00, irq_n}, {7'h00, lvl});
    if (irq_n !== lvl) print_verdict();
  endtask
  initial begin
    repeat (16) @(negedge clock);
    rst <= 1'b0;
    wr(OFS_SYNC_LIVE_STATUS, 8'hff);
    rd(OFS_SYNC_LIVE_STATUS, v);
    chk(v, 8'h04);
    rd(OFS_ALARM_MASK_ONE, v);
    chk(v, RST_MASK);
    rd(8'h00, v);
    chk(v, RD_UNMAPPED);
    link_irq <= 1'b1;
    wait_irq(1'b0, 4, n);
    link_irq <= 1'b0;
    wait_irq(1'b1, 4, n);
    $display("Reset and map test done");
    wr(OFS_ALARM_MASK_ONE, 8'h10);
    pulse(17'h08000);
    wait_irq(1'b0, 4, n);
    wr(OFS_RX_ALARM_STATUS, 8'h00);
    rd(OFS_RX_ALARM_STATUS, v);
    chk(v & 8'h10, 8'h00);
    wr(OFS_RX_ALARM_STATUS, 8'h10);
    rd(OFS_RX_ALARM_STATUS, v);
    chk(v & 8'h10, 8'h10);
    wr(OFS_RX_ALARM_STATUS, v & 8'h10);
    wait_irq(1'b1, 4, n);
    wr(OFS_RX_ALARM_STATUS, 8'h10);
    rd(OFS_RX_ALARM_STATUS, v);
    chk(v & 8'h10, 8'h00);
    wr(OFS_EVENT_MASK_TWO, 8'h01);
    @(negedge clock) ev2 <= 8'h01;
    @(negedge clock) ev2 <= 8'h00;
    wait_irq(1'b0, 4, n);
    wr(OFS_EVENT_STATUS_TWO, 8'h01);
    rd(OFS_EVENT_STATUS_TWO, v);
    chk(v, 8'h01);
    wait_irq(1'b1, 4, n);
    $display("Slip event test done");
    pulse(17'h03c20);
    pulse(17'h000c0);
    pulse(17'h000c0);
    pulse(17'h00080);
    pulse(17'h000c0);
    pulse(17'h000c0);
    wr(OFS_RX_INFORMATION, 8'hff);
    rd(OFS_RX_INFORMATION, v);
    chk(v, 8'hd9);
    pulse(17'h000c0);
    jfill <= 8'h60;
    wr(OFS_RX_INFORMATION, 8'hff);
    rd(OFS_RX_INFORMATION, v);
    chk(v, 8'h22);
    repeat (915) pulse(17'h00300);
    wr(OFS_RX_INFORMATION, 8'hff);
    rd(OFS_RX_INFORMATION, v);
    chk(v, 8'h24);
    $display("Information test done");
    crc_en <= 1'b1;
    for (int i = 1; i <= 69; i++) begin
      pulse(17'h00010);
      rd(OFS_SYNC_LIVE_STATUS, v);
      c = i[5:0];
      chk(v, {c[5:2], c[0], 3'b100});
    end
    crc_en <= 1'b0;
    rd(OFS_SYNC_LIVE_STATUS, v);
    chk(v, 8'h04);
    crc_en <= 1'b1;
    pulse(17'h00010);
    pulse(17'h00008);
    rd(OFS_SYNC_LIVE_STATUS, v);
    chk(v, 8'h04);
    $display("Sync counter test done");
    wr(OFS_ALARM_MASK_ONE, 8'h02);
    ones <= 1'b0;
    wait_irq(1'b0, 300, n);
    chk(8'(n > 250), 8'h01);
    wr(OFS_RX_ALARM_STATUS, 8'h02);
    rd(OFS_RX_ALARM_STATUS, v);
    chk(v & 8'h02, 8'h02);
    wr(OFS_RX_ALARM_STATUS, v & 8'h02);
    wait_irq(1'b1, 4, n);
    wr(OFS_RX_ALARM_STATUS, 8'h02);
    rd(OFS_RX_ALARM_STATUS, v);
    chk(v & 8'h02, 8'h02);
    ones <= 1'b1;
    wait_irq(1'b0, 600, n);
    wr(OFS_RX_ALARM_STATUS, 8'h02);
    rd(OFS_RX_ALARM_STATUS, v);
    chk(v & 8'h02, 8'h02);
    wait_irq(1'b1, 4, n);
    alt <= 1'b1;
    ones <= 1'b0;
    wait_irq(1'b0, 2100, n);
    chk(8'(n > 2040), 8'h01);
    $display("Carrier loss test done");
    print_verdict();
  end
endmodule // e1_status_alarm_registers_tb
